// ---- rtl/gpk_defines.vh ----
`ifndef GPK_DEFINES_VH
`define GPK_DEFINES_VH

// Register byte offsets
`define GPK_OFF_DATA    12'h000
`define GPK_OFF_DIR     12'h004
`define GPK_OFF_PULL    12'h008
`define GPK_OFF_SLEW    12'h00c
`define GPK_OFF_DRIVE   12'h010
`define GPK_OFF_IRQSC   12'h014
`define GPK_OFF_IRQSEL  12'h018
`define GPK_OFF_IRQPOL  12'h01c
`define GPK_OFF_PINLVL  12'h020
`define GPK_OFF_PWR     12'h024

// Interrupt status and control fields
`define GPK_SC_MODE     0
`define GPK_SC_IE       1
`define GPK_SC_ACK      2
`define GPK_SC_FLAG     3

// Power status fields
`define GPK_PWR_FLAG    0
`define GPK_PWR_ACK     1

// Reset values
`define GPK_RST_BYTE    8'h00
`define GPK_RST_SLEW    8'hff

// Pins that have no input buffer
`define GPK_OUT_ONLY    8'h00

// Unused read bits
`define GPK_RD_ZERO     32'h0000_0000

`endif

// ---- rtl/gpk_sync.v ----
module gpk_sync (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       ce,
    input  wire [7:0] raw,
    output reg  [7:0] stable
);

    reg [7:0] s1;
    reg [7:0] s2;
    reg [7:0] s3;

    // Three stages; value accepted once stages two and three agree
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1     <= 8'h00;
            s2     <= 8'h00;
            s3     <= 8'h00;
            stable <= 8'h00;
        end
        else if (ce)
        begin
            s1     <= raw;
            s2     <= s1;
            s3     <= s2;
            stable <= (s2 & s3) | (stable & (s2 ^ s3));
        end
    end

endmodule // gpk_sync

// ---- rtl/gpk_port.v ----
// Operation
// - Direction bit enables output buffer and picks data-read source.
// - Input buffer always on except analog function or output-only pin; pad_ie resets to 0 and stays off until the first enabled clock after reset.
// - Shared digital function drives output enable; direction still picks read source.
// - Analog function disables both buffers; input-direction read returns 0.
// - Analog function wins over alternate digital function on a pin.
// - Pull enable works, but is forced off for outputs or analog pins.
// - Slew limit reaches the pad only for pins driving as outputs.
// - High-drive bit requests stronger pad drive for that pin.
// - Port pins serve as interrupt inputs and low-power wake sources.
// - Per-pin select bit; only selected pins join interrupt detection.
// - Port mode bit picks edge-only or edge-and-level sensitivity.
// - Per-pin polarity chooses falling/low or rising/high as asserted.
// - Edges found synchronously: one cycle sample then opposite next cycle.
// - Edge counts only after enabled input first seen deasserted.
// - Edge-only: edge sets flag; request when flag and enable set.
// - Edge-only: writing 1 to acknowledge clears the flag.
// - Edge-and-level: edge or asserted level sets flag, gated by enable.
// - Edge-and-level: acknowledge clears only when all enabled pins deasserted.
// - Interrupt pins with pull on: polarity 0 pull-up, 1 pull-down.
// - Partial power-down holds pin latches; software checks flag, acknowledges.
// - Retained sleep keeps all state and resumes at once.
// - Reset disables shared functions and makes every pin an input.
// - Enabled peripheral overrides general-purpose function on shared pin.
// - Output-pin data read returns last written value.
//
// The address map and register access over APB were decided locally.
`include "gpk_defines.vh"

module gpk_port (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        ce,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [7:0]  pad_in,
    output reg  [7:0]  pad_out,
    output reg  [7:0]  pad_oe,
    output reg  [7:0]  pad_ie,
    output reg  [7:0]  pad_pull_en,
    output reg  [7:0]  pad_pull_up,
    output reg  [7:0]  pad_slew,
    output reg  [7:0]  pad_drive_hi,
    input  wire [7:0]  alt_en,
    input  wire [7:0]  alt_oe,
    input  wire [7:0]  alt_out,
    input  wire [7:0]  analog_en,
    input  wire        io_hold,
    input  wire        powerdown_wake,
    output reg         irq_req,
    output reg         wake_req
);

    reg  [7:0]  data_out;
    reg  [7:0]  pin_dir;
    reg  [7:0]  pull_enable_reg;
    reg  [7:0]  slew_limit;
    reg  [7:0]  high_drive;
    reg  [7:0]  irq_pin_select_reg;
    reg  [7:0]  irq_polarity_reg;
    reg         irq_detect_mode;
    reg         irq_enable;
    reg         irq_flag;
    reg         partial_powerdown_flag;
    reg  [7:0]  prev_asserted;
    reg  [7:0]  prev_select;
    wire [7:0]  pin_level;

    reg  [7:0]  next_out;
    reg  [7:0]  next_oe;
    reg  [7:0]  next_ie;
    reg  [7:0]  next_pull_en;
    reg  [7:0]  next_pull_up;
    reg  [7:0]  next_slew;
    reg  [31:0] next_rdata;
    reg         next_err;

    wire [7:0]  asserted;
    wire [7:0]  edge_hit;
    wire        level_hit;
    wire        flag_set;
    wire        wr_go;
    wire        ack_wr;
    wire        ppd_ack_wr;
    wire [7:0]  data_rd;

    function hit;
        input [11:0] a;
        input [11:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    gpk_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .raw     (pad_in),
        .stable  (pin_level)
    );

    // Asserted level per pin, polarity 1 = high
    assign asserted  = ~(pin_level ^ irq_polarity_reg);
    // Edge: deasserted sample while selected, then asserted sample
    assign edge_hit  = irq_pin_select_reg & prev_select & ~prev_asserted
                       & asserted;
    assign level_hit = irq_detect_mode & |(irq_pin_select_reg & asserted);
    assign flag_set  = |edge_hit | level_hit;

    assign wr_go      = psel & penable & pready & pwrite;
    assign ack_wr     = wr_go & hit(paddr, `GPK_OFF_IRQSC) & pwdata[`GPK_SC_ACK];
    assign ppd_ack_wr = wr_go & hit(paddr, `GPK_OFF_PWR) & pwdata[`GPK_PWR_ACK];

    // Data read source
    assign data_rd = (pin_dir & data_out) | (~pin_dir & next_ie & pin_level);

    // Pad control
    always @*
    begin
        next_ie      = ~analog_en & ~(`GPK_OUT_ONLY);
        next_oe      = ~analog_en & ((alt_en & alt_oe) | (~alt_en & pin_dir));
        next_out     = (alt_en & alt_out) | (~alt_en & data_out);
        next_pull_en = pull_enable_reg & ~next_oe & ~analog_en;
        next_pull_up = ~(irq_pin_select_reg & irq_polarity_reg);
        next_slew    = slew_limit & next_oe;
    end

    // Read mux and decode
    always @*
    begin
        next_rdata = `GPK_RD_ZERO;
        next_err   = 1'b0;
        if (hit(paddr, `GPK_OFF_DATA))
            next_rdata[7:0] = data_rd;
        else if (hit(paddr, `GPK_OFF_DIR))
            next_rdata[7:0] = pin_dir;
        else if (hit(paddr, `GPK_OFF_PULL))
            next_rdata[7:0] = pull_enable_reg;
        else if (hit(paddr, `GPK_OFF_SLEW))
            next_rdata[7:0] = slew_limit;
        else if (hit(paddr, `GPK_OFF_DRIVE))
            next_rdata[7:0] = high_drive;
        else if (hit(paddr, `GPK_OFF_IRQSC))
        begin
            next_rdata[`GPK_SC_MODE] = irq_detect_mode;
            next_rdata[`GPK_SC_IE]   = irq_enable;
            next_rdata[`GPK_SC_FLAG] = irq_flag;
        end
        else if (hit(paddr, `GPK_OFF_IRQSEL))
            next_rdata[7:0] = irq_pin_select_reg;
        else if (hit(paddr, `GPK_OFF_IRQPOL))
            next_rdata[7:0] = irq_polarity_reg;
        else if (hit(paddr, `GPK_OFF_PINLVL))
            next_rdata[7:0] = pin_level;
        else if (hit(paddr, `GPK_OFF_PWR))
            next_rdata[`GPK_PWR_FLAG] = partial_powerdown_flag;
        else
            next_err = 1'b1;
    end

    // APB handshake: one wait state
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            prdata  <= `GPK_RD_ZERO;
            pslverr <= 1'b0;
        end
        else if (ce)
        begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & next_err;
            if (psel & penable & ~pready & ~pwrite)
                prdata <= next_rdata;
        end
    end

    // Software registers
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            data_out           <= `GPK_RST_BYTE;
            pin_dir            <= `GPK_RST_BYTE;
            pull_enable_reg    <= `GPK_RST_BYTE;
            slew_limit         <= `GPK_RST_SLEW;
            high_drive         <= `GPK_RST_BYTE;
            irq_pin_select_reg <= `GPK_RST_BYTE;
            irq_polarity_reg   <= `GPK_RST_BYTE;
            irq_detect_mode    <= 1'b0;
            irq_enable         <= 1'b0;
        end
        else if (ce & wr_go)
        begin
            if (hit(paddr, `GPK_OFF_DATA))
                data_out <= pwdata[7:0];
            else if (hit(paddr, `GPK_OFF_DIR))
                pin_dir <= pwdata[7:0];
            else if (hit(paddr, `GPK_OFF_PULL))
                pull_enable_reg <= pwdata[7:0];
            else if (hit(paddr, `GPK_OFF_SLEW))
                slew_limit <= pwdata[7:0];
            else if (hit(paddr, `GPK_OFF_DRIVE))
                high_drive <= pwdata[7:0];
            else if (hit(paddr, `GPK_OFF_IRQSC))
            begin
                irq_detect_mode <= pwdata[`GPK_SC_MODE];
                irq_enable      <= pwdata[`GPK_SC_IE];
            end
            else if (hit(paddr, `GPK_OFF_IRQSEL))
                irq_pin_select_reg <= pwdata[7:0];
            else if (hit(paddr, `GPK_OFF_IRQPOL))
                irq_polarity_reg <= pwdata[7:0];
        end
    end

    // Interrupt detection and flag; set wins over acknowledge
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev_asserted <= 8'h00;
            prev_select   <= 8'h00;
            irq_flag      <= 1'b0;
            irq_req       <= 1'b0;
            wake_req      <= 1'b0;
        end
        else if (ce)
        begin
            prev_asserted <= asserted;
            prev_select   <= irq_pin_select_reg;
            if (flag_set)
                irq_flag <= 1'b1;
            else if (ack_wr)
                irq_flag <= 1'b0;
            irq_req  <= (irq_flag | flag_set) & irq_enable;
            wake_req <= (irq_flag | flag_set) & irq_enable;
        end
    end

    // Partial power-down recovery flag
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            partial_powerdown_flag <= 1'b0;
        else if (ce)
        begin
            if (powerdown_wake)
                partial_powerdown_flag <= 1'b1;
            else if (ppd_ack_wr)
                partial_powerdown_flag <= 1'b0;
        end
    end

    // Pad outputs; frozen while held through partial power-down
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pad_out      <= 8'h00;
            pad_oe       <= 8'h00;
            pad_ie       <= 8'h00;
            pad_pull_en  <= 8'h00;
            pad_pull_up  <= 8'hff;
            pad_slew     <= 8'h00;
            pad_drive_hi <= 8'h00;
        end
        else if (ce & ~io_hold)
        begin
            pad_out      <= next_out;
            pad_oe       <= next_oe;
            pad_ie       <= next_ie;
            pad_pull_en  <= next_pull_en;
            pad_pull_up  <= next_pull_up;
            pad_slew     <= next_slew;
            pad_drive_hi <= high_drive;
        end
    end

endmodule // gpk_port

// ---- sim/gpk_port_monitor.sv ----
`include "gpk_defines.vh"
module gpk_port_monitor (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       ce,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pwrite,
    input wire logic       pready,
    input wire logic [11:0] paddr,
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] pad_ie,
    input wire logic [7:0] pad_pull_en,
    input wire logic [7:0] pad_slew,
    input wire logic [7:0] alt_en,
    input wire logic [7:0] alt_oe,
    input wire logic [7:0] analog_en,
    input wire logic       io_hold,
    input wire logic       irq_req,
    input wire logic       wake_req
);
    timeunit 1ns;
    timeprecision 1ps;
    wire ctrl_wr = psel && penable && pready && pwrite && (paddr == `GPK_OFF_IRQSC);
    wire [7:0] alt_own = alt_en & ~analog_en;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_hold;
        io_hold ##1 io_hold;
    endsequence
    a_analog_no_oe: assert property (ce && !io_hold |=> (pad_oe & $past(analog_en)) == 8'h00)
        else $error("analog pin drives");
    a_analog_no_ie: assert property (ce && !io_hold |=> (pad_ie & $past(analog_en)) == 8'h00)
        else $error("analog pin input on");
    a_alt_owns_oe: assert property (ce && !io_hold |=>
        (pad_oe & $past(alt_own)) == $past(alt_oe & alt_own))
        else $error("alt enable not followed");
    a_pull_forced_off: assert property (ce && !io_hold |=>
        (pad_pull_en & (pad_oe | $past(analog_en))) == 8'h00)
        else $error("pull on for output");
    a_slew_out_only: assert property ((pad_slew & ~pad_oe) == 8'h00)
        else $error("slew on input");
    a_wake_tracks_irq: assert property (wake_req == irq_req)
        else $error("wake differs from irq");
    a_irq_stays_set: assert property (irq_req && !ctrl_wr && !$past(ctrl_wr) |=> irq_req)
        else $error("irq dropped without write");
    a_hold_freezes: assert property (s_hold |-> $stable(pad_oe) && $stable(pad_out))
        else $error("pads moved under hold");
endmodule // gpk_port_monitor

bind gpk_port gpk_port_monitor u_mon (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_ie(pad_ie), .pad_pull_en(pad_pull_en), .pad_slew(pad_slew),
    .alt_en(alt_en), .alt_oe(alt_oe), .analog_en(analog_en), .io_hold(io_hold),
    .irq_req(irq_req), .wake_req(wake_req));

// ---- sim/gpk_pins.sv ----
module gpk_pins (
    input wire logic       pclk,
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] pad_pull_en,
    input wire logic [7:0] pad_pull_up,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_drv,
    output logic     [7:0] pad_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] flt = 8'h55;
    // Undriven pins wander every cycle
    always @(posedge pclk)
        flt <= ~flt;
    // Own driver, far driver, pull, else wandering
    always_comb
        pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_drv)
               | (~pad_oe & ~ext_en & pad_pull_en & pad_pull_up)
               | (~pad_oe & ~ext_en & ~pad_pull_en & flt);
endmodule // gpk_pins

// ---- sim/gpk_port_tb.sv ----
`include "gpk_defines.vh"
module gpk_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, ce, psel, penable, pwrite, io_hold, powerdown_wake;
    logic        pready, pslverr, irq_req, wake_req;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0]  pad_in, pad_out, pad_oe, pad_ie, pad_pull_en, pad_pull_up, pad_slew;
    logic [7:0]  pad_drive_hi, alt_en, alt_oe, alt_out, analog_en, ext_en, ext_drv, r, e;
    logic [32:0] q[$];
    int          n_fail = 0;
    int          n_tests = 0;

    gpk_port uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_ie(pad_ie), .pad_pull_en(pad_pull_en), .pad_pull_up(pad_pull_up),
        .pad_slew(pad_slew), .pad_drive_hi(pad_drive_hi), .alt_en(alt_en), .alt_oe(alt_oe),
        .alt_out(alt_out), .analog_en(analog_en), .io_hold(io_hold),
        .powerdown_wake(powerdown_wake), .irq_req(irq_req), .wake_req(wake_req));
    gpk_pins u_pins (.pclk(pclk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_en(pad_pull_en),
        .pad_pull_up(pad_pull_up), .ext_en(ext_en), .ext_drv(ext_drv), .pad_in(pad_in));

    task chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task apb(input logic [11:0] a, input logic w, input logic [7:0] d);
        int n;
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
        psel <= 0;
        penable <= 0;
        // Idle edge so the next setup never re-drives psel in this time step
        @(posedge pclk);
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        apb(a, 1, d);
    endtask
    task rd(input logic [11:0] a, input logic [32:0] x);
        q.push_back(x);
        apb(a, 0, 8'h00);
    endtask
    task t(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task close_out;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Read results checked as they come back
    always @(posedge pclk)
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk("rdata", {pslverr, prdata}, q.pop_front());

    initial
    begin
        pclk = 0;
        forever #5 pclk = ~pclk;
    end
    initial
    begin
        #100000;
        n_fail++;
        close_out;
    end
    initial
    begin
        {presetn, psel, penable, pwrite, io_hold, powerdown_wake} = 6'h00;
        {paddr, pwdata, alt_en, alt_oe, alt_out, analog_en, ext_en, ext_drv} = 92'h0;
        ce = 1;
        void'($urandom(55831));
        t(12);
        presetn <= 1;
        t(1);
        rd(`GPK_OFF_DIR, 33'h0);
        rd(`GPK_OFF_SLEW, 33'h0ff);
        chk("oe", pad_oe, 33'h0);
        chk("ie", pad_ie, 33'h0ff);
        $display("reset done");
        r = $urandom;
        e = $urandom;
        ext_en <= 8'hf0;
        ext_drv <= e;
        wr(`GPK_OFF_DATA, r);
        wr(`GPK_OFF_DIR, 8'h0f);
        wr(`GPK_OFF_PULL, 8'hff);
        wr(`GPK_OFF_DRIVE, 8'h5a);
        t(8);
        rd(`GPK_OFF_DATA, (r & 8'h0f) | (e & 8'hf0));
        chk("oe", pad_oe, 33'h0f);
        chk("out", pad_out & 8'h0f, r & 8'h0f);
        chk("slew", pad_slew, 33'h0f);
        chk("pull", pad_pull_en, 33'hf0);
        chk("drive", pad_drive_hi & 8'h0f, 33'h0a);
        $display("data done");
        alt_en <= 8'h03;
        alt_oe <= 8'h02;
        alt_out <= 8'h02;
        analog_en <= 8'h81;
        t(4);
        chk("oe", pad_oe, 33'h0e);
        chk("ie", pad_ie, 33'h7e);
        chk("alt", pad_out & 8'h02, 33'h02);
        chk("pull", pad_pull_en, 33'h70);
        rd(`GPK_OFF_DATA, ((r & 8'h0f) | (e & 8'hf0)) & 8'h7f);
        rd(12'h030, 33'h1_0000_0000);
        {alt_en, analog_en} <= 16'h0;
        $display("sharing done");
        ext_en <= 8'hff;
        ext_drv <= 8'h00;
        wr(`GPK_OFF_DIR, 8'h00);
        wr(`GPK_OFF_IRQSC, 8'h00);
        wr(`GPK_OFF_IRQPOL, 8'h01);
        wr(`GPK_OFF_PULL, 8'h01);
        wr(`GPK_OFF_IRQSEL, 8'h01);
        wr(`GPK_OFF_IRQSC, 8'h04);
        wr(`GPK_OFF_IRQSC, 8'h02);
        t(8);
        chk("pullup", pad_pull_up & 8'h01, 33'h0);
        ext_drv <= 8'h02;
        t(8);
        chk("irq", irq_req, 33'h0);
        ext_drv <= 8'h03;
        t(8);
        chk("irq", irq_req, 33'h1);
        chk("wake", wake_req, 33'h1);
        rd(`GPK_OFF_IRQSC, 33'h0a);
        ext_drv <= 8'h00;
        t(8);
        wr(`GPK_OFF_IRQSC, 8'h06);
        t(2);
        chk("irq", irq_req, 33'h0);
        // Polarity flip makes an edge; mask, flip, acknowledge, re-enable
        wr(`GPK_OFF_IRQSC, 8'h00);
        wr(`GPK_OFF_IRQPOL, 8'h00);
        wr(`GPK_OFF_IRQSC, 8'h04);
        wr(`GPK_OFF_IRQSC, 8'h02);
        t(8);
        chk("irq", irq_req, 33'h0);
        chk("pullup", pad_pull_up & 8'h01, 33'h1);
        ext_drv <= 8'h01;
        t(8);
        chk("irq", irq_req, 33'h0);
        ext_drv <= 8'h00;
        t(8);
        chk("irq", irq_req, 33'h1);
        wr(`GPK_OFF_IRQSC, 8'h07);
        t(2);
        chk("irq", irq_req, 33'h1);
        ext_drv <= 8'h01;
        t(8);
        wr(`GPK_OFF_IRQSC, 8'h07);
        t(2);
        chk("irq", irq_req, 33'h0);
        $display("irq done");
        ext_en <= 8'h00;
        io_hold <= 1;
        wr(`GPK_OFF_DIR, 8'hff);
        t(4);
        chk("oe", pad_oe, 33'h0);
        powerdown_wake <= 1;
        t(1);
        powerdown_wake <= 0;
        rd(`GPK_OFF_PWR, 33'h1);
        wr(`GPK_OFF_PWR, 8'h02);
        rd(`GPK_OFF_PWR, 33'h0);
        io_hold <= 0;
        t(4);
        chk("oe", pad_oe, 33'hff);
        $display("hold done");
        close_out;
    end
endmodule // gpk_port_tb
